// ==== btcc_pkg.sv ====
/*
   Constants and types for the time and calendar counter block.
   Assumes nothing beyond a SystemVerilog compiler; no imports are used.
*/
`default_nettype none
package btcc_pkg;

   // ------------------------------------------------------------------
   // Register offsets
   // ------------------------------------------------------------------
   localparam logic [2:0] OFS_SECONDS = 3'h0;
   localparam logic [2:0] OFS_MINUTES = 3'h1;
   localparam logic [2:0] OFS_HOURS = 3'h2;
   localparam logic [2:0] OFS_WEEKDAY = 3'h3;
   localparam logic [2:0] OFS_DAY = 3'h4;
   localparam logic [2:0] OFS_MONTH = 3'h5;
   localparam logic [2:0] OFS_YEAR = 3'h6;
   localparam logic [2:0] OFS_RATE_TRIM = 3'h7;

   // ------------------------------------------------------------------
   // Field masks: bits outside a mask read zero and ignore writes, except month bit 7, which holds the century bit
   // ------------------------------------------------------------------
   localparam logic [7:0] MASK_SECONDS = 8'h7F;
   localparam logic [7:0] MASK_MINUTES = 8'h7F;
   localparam logic [7:0] MASK_HOURS = 8'h3F;
   localparam logic [7:0] MASK_WEEKDAY = 8'h07;
   localparam logic [7:0] MASK_DAY = 8'h3F;
   localparam logic [7:0] MASK_MONTH = 8'h1F;
   localparam logic [7:0] MASK_YEAR = 8'hFF;
   localparam logic [7:0] MASK_RATE_TRIM = 8'h7F;
   localparam int CENTURY_BIT = 7;

   // ------------------------------------------------------------------
   // BCD limits
   // ------------------------------------------------------------------
   localparam logic [7:0] BCD_ZERO = 8'h00;
   localparam logic [7:0] BCD_ONE = 8'h01;
   localparam logic [7:0] BCD_59 = 8'h59;
   localparam logic [7:0] BCD_23 = 8'h23;
   localparam logic [7:0] BCD_11 = 8'h11;
   localparam logic [7:0] BCD_12 = 8'h12;
   localparam logic [7:0] BCD_99 = 8'h99;
   localparam logic [7:0] BCD_20 = 8'h20;
   localparam logic [7:0] BCD_40 = 8'h40;
   localparam logic [7:0] DAYS_31 = 8'h31;
   localparam logic [7:0] DAYS_30 = 8'h30;
   localparam logic [7:0] DAYS_29 = 8'h29;
   localparam logic [7:0] DAYS_28 = 8'h28;
   localparam logic [7:0] MON_FEB = 8'h02;
   localparam logic [7:0] MON_APR = 8'h04;
   localparam logic [7:0] MON_JUN = 8'h06;
   localparam logic [7:0] MON_SEP = 8'h09;
   localparam logic [7:0] MON_NOV = 8'h11;
   localparam logic [2:0] WDAY_LAST = 3'h6;
   localparam int HOUR_PM_BIT = 5;

   // ------------------------------------------------------------------
   // Prescaler and trim
   // ------------------------------------------------------------------
   localparam logic [16:0] XTAL_PER_SECOND = 17'h08000;
   localparam int TRIM_DIR_BIT = 6;
   localparam logic [7:0] TRIM_RESET = 8'h00;

   // Reset values of the counters
   localparam logic [7:0] RST_DAY = 8'h01;
   localparam logic [7:0] RST_MONTH = 8'h01;

   // One full time and calendar value
   typedef struct packed {
      logic century;
      logic [7:0] year;
      logic [7:0] month;
      logic [7:0] day;
      logic [2:0] wday;
      logic [7:0] hour;
      logic [7:0] min;
      logic [7:0] sec;
   } btcc_time_t;

endpackage
`default_nettype wire

// ==== btcc_counters.sv ====
/*
   BCD time and calendar counters with second-rate trim.
   Holds seconds, minutes, hours, weekday, day, month with century bit,
   year, the crystal prescaler, the rate trim register and the halt flag.
   Assumes a parallel register port driven on clk_sys by a serial front
   end, with one-cycle write strobes and a level address that also
   selects the read data one cycle later.
   Assumes the crystal clock and the crystal-stop indication arrive
   asynchronously to clk_sys and are synchronised here.
*/
// Operation
// - seconds 00-59, carry into minutes
// - minutes 00-59, carry into hours
// - hour rollover carries day and weekday
// - 12-hour: midnight 12, noon 32
// - seconds write clears sub-second prescaler
// - weekday increments on each hour carry
// - weekday wraps 110 to 000
// - month length with leap February
// - day past month end reloads, month increments
// - month 1-12, carry into year
// - year 00-99, divisible by four leap
// - century bit toggles on year wrap
// - halt flag set when crystal stops
// - second equals 32768 crystal cycles untrimmed
// - trim only seconds 00, 20, 40
// - writing trim enables adjustment
// - no trim when coinciding with trim write
// - trim length formula per direction bit
// - middle five bits zero, no trim
`timescale 1ns/1ps
`default_nettype none
module btcc_counters (
   // Clock and reset
   input wire logic clk_sys,
   input wire logic reset_n,
   // Asynchronous crystal side
   input wire logic xtal_clk,
   input wire logic osc_stop,
   // Register port
   input wire logic reg_wr_en,
   input wire logic [2:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   output logic [7:0] reg_rdata_q,
   // Control and status
   input wire logic mode_24h,
   input wire logic osc_halt_clear,
   output logic osc_halt_flag_q,
   output logic sec_tick_q
);

   // -------------------------------------------------------------------
   // State
   // -------------------------------------------------------------------
   // Live time value, its next value and the ticked value
   btcc_pkg::btcc_time_t time_q;
   btcc_pkg::btcc_time_t time_d;
   btcc_pkg::btcc_time_t time_adv;
   // Trim register and its armed flag
   logic [7:0] rate_trim_q;
   logic trim_active_q;
   // Crystal edge count and the length of the current second
   logic [16:0] presc_q;
   logic [16:0] period_q;
   logic xtal_s1_q;
   logic xtal_s2_q;
   logic xtal_s3_q;
   logic stop_s1_q;
   logic stop_s2_q;

   // Shared by every BCD counter field; the caller gives the last legal
   // value and the value to reload after it. Only legal BCD inputs are
   // expected, so a nibble above nine is not guarded against.
   // BCD increment with wrap: returns {carry, next}
   function automatic logic [8:0] bcd_inc(input logic [7:0] v,
                                          input logic [7:0] last,
                                          input logic [7:0] first);
      logic [8:0] r;
      r = {1'b0, v};
      if (v == last) begin
         r = {1'b1, first};
      end else if (v[3:0] == 4'h9) begin
         r = {1'b0, v[7:4] + 4'h1, 4'h0};
      end else begin
         r = {1'b0, v[7:4], v[3:0] + 4'h1};
      end
      return r;
   endfunction

   // -------------------------------------------------------------------
   // Synchronisers and crystal edge detect
   // -------------------------------------------------------------------
   // Two flops per async input, third flop only for edge finding
   // These flops carry no reset: they only follow the pins, and the
   // prescaler ignores them while reset_n is low, so nothing is
   // counted before reset is released.
   always_ff @(posedge clk_sys) begin
      xtal_s1_q <= xtal_clk;
      xtal_s2_q <= xtal_s1_q;
      xtal_s3_q <= xtal_s2_q;
      stop_s1_q <= osc_stop;
      stop_s2_q <= stop_s1_q;
   end

   // A crystal rise is one clk_sys cycle wide; the crystal must stay
   // high and low for at least two clk_sys periods for none to be lost
   wire xtal_rise = xtal_s2_q & ~xtal_s3_q;

   // -------------------------------------------------------------------
   // Register port decode
   // -------------------------------------------------------------------
   // One strobe per register; the address alone also drives the read
   // multiplexer, so reads need no strobe of their own; a write and a
   // read of one register in one cycle return the old value
   wire wr_sec = reg_wr_en && (reg_addr == btcc_pkg::OFS_SECONDS);
   wire wr_min = reg_wr_en && (reg_addr == btcc_pkg::OFS_MINUTES);
   wire wr_hour = reg_wr_en && (reg_addr == btcc_pkg::OFS_HOURS);
   wire wr_wday = reg_wr_en && (reg_addr == btcc_pkg::OFS_WEEKDAY);
   wire wr_day = reg_wr_en && (reg_addr == btcc_pkg::OFS_DAY);
   wire wr_month = reg_wr_en && (reg_addr == btcc_pkg::OFS_MONTH);
   wire wr_year = reg_wr_en && (reg_addr == btcc_pkg::OFS_YEAR);
   wire wr_trim = reg_wr_en && (reg_addr == btcc_pkg::OFS_RATE_TRIM);

   // -------------------------------------------------------------------
   // Prescaler and trimmed period
   // -------------------------------------------------------------------
   // One second ends when the counted crystal edges reach the period
   // The period is latched at the start of each interval, so a trim
   // write in mid-second only affects the next interval that starts
   // at 00, 20 or 40 seconds.
   wire tick = xtal_rise && (presc_q == period_q - 17'h00001);
   wire [5:0] trim_amt = rate_trim_q[5:0];
   wire trim_dir = rate_trim_q[btcc_pkg::TRIM_DIR_BIT];
   wire trim_nonzero = |rate_trim_q[5:1];
   wire [6:0] trim_loss = {1'b0, trim_amt} - 7'h01;
   wire [6:0] trim_gain = {1'b0, ~trim_amt} + 7'h01;
   // The loss and gain terms stay within seven bits for every trim
   // value except 0, where trim_loss wraps to 7'h7F, so the period never wraps below or above its range
   // Longer or shorter second by twice the programmed step
   wire [16:0] period_long =
      btcc_pkg::XTAL_PER_SECOND + {9'h000, trim_loss, 1'b0};
   wire [16:0] period_short =
      btcc_pkg::XTAL_PER_SECOND - {9'h000, trim_gain, 1'b0};
   wire [16:0] period_trim = trim_dir ? period_short : period_long;

   // A seconds write both restarts the interval and decides, from the
   // written value, whether that interval is trimmed
   // Seconds value at which the next interval starts
   wire [7:0] sec_start = wr_sec ? (reg_wdata & btcc_pkg::MASK_SECONDS)
                                 : time_adv.sec;
   wire sec_point = (sec_start == btcc_pkg::BCD_ZERO) ||
                    (sec_start == btcc_pkg::BCD_20) ||
                    (sec_start == btcc_pkg::BCD_40);
   wire apply_trim = sec_point && trim_active_q && trim_nonzero &&
                     !wr_trim;
   wire [16:0] period_next =
      apply_trim ? period_trim : btcc_pkg::XTAL_PER_SECOND;
   wire interval_start = tick || wr_sec;

   // Hazard: a seconds write in the same cycle as a tick wins; the
   // tick still advances the other fields, but seconds take the write
   // Prescaler: a seconds write restarts the second afresh
   always_ff @(posedge clk_sys) begin
      if (!reset_n) begin
         presc_q <= 17'h00000;
         period_q <= btcc_pkg::XTAL_PER_SECOND;
      end else if (interval_start) begin
         presc_q <= 17'h00000;
         period_q <= period_next;
      end else if (xtal_rise) begin
         presc_q <= presc_q + 17'h00001;
      end
   end

   // -------------------------------------------------------------------
   // Carry chain, all fields within one update
   // -------------------------------------------------------------------
   // Every carry is formed from the current value in one cycle, so a
   // read never sees a half-carried time; a field only steps when all
   // fields below it wrap on the same tick
   wire [8:0] sec_inc = bcd_inc(time_q.sec, btcc_pkg::BCD_59,
                                btcc_pkg::BCD_ZERO);
   wire [8:0] min_inc = bcd_inc(time_q.min, btcc_pkg::BCD_59,
                                btcc_pkg::BCD_ZERO);
   wire c_sec = sec_inc[8];
   wire c_min = c_sec && min_inc[8];

   // Hours: 24-hour wraps 23 to 00; 12-hour uses bit 5 as PM
   // In 12-hour mode the low five bits run 12, 01 .. 11; the afternoon
   // bit flips on the step from 11 to 12, and only the step from
   // afternoon 11 to 12 carries into the day
   wire hour_pm = time_q.hour[btcc_pkg::HOUR_PM_BIT];
   wire [7:0] hour_low = {3'h0, time_q.hour[4:0]};
   wire [8:0] h24_inc = bcd_inc(time_q.hour, btcc_pkg::BCD_23,
                                btcc_pkg::BCD_ZERO);
   wire [8:0] h12_inc = bcd_inc(hour_low, btcc_pkg::BCD_12,
                                btcc_pkg::BCD_ONE);
   wire h12_at_11 = (hour_low == btcc_pkg::BCD_11);
   wire [7:0] h12_next = {2'b00, hour_pm ^ h12_at_11,
                          h12_inc[4:0]};
   wire h12_carry = hour_pm && h12_at_11;
   wire [7:0] hour_next = mode_24h ? h24_inc[7:0] : h12_next;
   wire c_hour = c_min && (mode_24h ? h24_inc[8] : h12_carry);

   // Month length, leap years from BCD year mod four
   // Ten is two more than a multiple of four, so an odd tens digit adds
   // two to the units before the two low bits are tested
   wire [3:0] year_mod = time_q.year[3:0] + {2'b00, time_q.year[4], 1'b0};
   wire leap = (year_mod[1:0] == 2'b00);
   wire short_mon = (time_q.month == btcc_pkg::MON_APR) ||
                    (time_q.month == btcc_pkg::MON_JUN) ||
                    (time_q.month == btcc_pkg::MON_SEP) ||
                    (time_q.month == btcc_pkg::MON_NOV);
   wire [7:0] feb_last = leap ? btcc_pkg::DAYS_29 : btcc_pkg::DAYS_28;
   wire [7:0] last_day =
      (time_q.month == btcc_pkg::MON_FEB) ? feb_last :
      short_mon ? btcc_pkg::DAYS_30 : btcc_pkg::DAYS_31;
   wire [8:0] day_inc = bcd_inc(time_q.day, last_day,
                                btcc_pkg::BCD_ONE);
   wire c_day = c_hour && day_inc[8];
   wire [8:0] mon_inc = bcd_inc(time_q.month, btcc_pkg::BCD_12,
                                btcc_pkg::BCD_ONE);
   wire c_mon = c_day && mon_inc[8];
   wire [8:0] year_inc = bcd_inc(time_q.year, btcc_pkg::BCD_99,
                                 btcc_pkg::BCD_ZERO);
   wire c_year = c_mon && year_inc[8];
   wire [2:0] wday_next = (time_q.wday == btcc_pkg::WDAY_LAST) ? 3'h0
                          : time_q.wday + 3'h1;

   // Advanced value: each field steps only when all lower fields wrap
   // Weekday and day both take the hour carry; month, year and century
   // follow the day carry in turn
   assign time_adv.sec = tick ? sec_inc[7:0] : time_q.sec;
   assign time_adv.min = (tick && c_sec) ? min_inc[7:0] : time_q.min;
   assign time_adv.hour = (tick && c_min) ? hour_next : time_q.hour;
   assign time_adv.wday = (tick && c_hour) ? wday_next
                                           : time_q.wday;
   assign time_adv.day = (tick && c_hour) ? day_inc[7:0] : time_q.day;
   assign time_adv.month = (tick && c_day) ? mon_inc[7:0]
                                           : time_q.month;
   assign time_adv.year = (tick && c_mon) ? year_inc[7:0]
                                          : time_q.year;
   assign time_adv.century = (tick && c_year) ? ~time_q.century
                                              : time_q.century;

   // Host writes override the advanced value of the written field
   // Bits outside each field are masked off here, so they never reach
   // the counters and always read back as zero, except month bit 7,
   // which loads the century bit; invalid values are stored as written
   // and are the host's concern
   assign time_d.sec = wr_sec ? (reg_wdata & btcc_pkg::MASK_SECONDS)
                              : time_adv.sec;
   assign time_d.min = wr_min ? (reg_wdata & btcc_pkg::MASK_MINUTES)
                              : time_adv.min;
   assign time_d.hour = wr_hour ? (reg_wdata & btcc_pkg::MASK_HOURS)
                                : time_adv.hour;
   assign time_d.wday = wr_wday ? reg_wdata[2:0] : time_adv.wday;
   assign time_d.day = wr_day ? (reg_wdata & btcc_pkg::MASK_DAY)
                              : time_adv.day;
   assign time_d.month = wr_month ? (reg_wdata & btcc_pkg::MASK_MONTH)
                                  : time_adv.month;
   assign time_d.year = wr_year ? reg_wdata : time_adv.year;
   assign time_d.century = wr_month ? reg_wdata[btcc_pkg::CENTURY_BIT]
                                    : time_adv.century;

   // Counter registers
   // Reset loads 00:00:00, weekday 0, day 01, month 01, year 00
   always_ff @(posedge clk_sys) begin
      if (!reset_n) begin
         time_q <= '0;
         time_q.day <= btcc_pkg::RST_DAY;
         time_q.month <= btcc_pkg::RST_MONTH;
      end else begin
         time_q <= time_d;
      end
   end

   // -------------------------------------------------------------------
   // Oscillation halt and trim register
   // -------------------------------------------------------------------
   // Halt flag: a stop indication wins over a clear in the same cycle
   // The flag stays set after the crystal restarts until the host
   // clears it, so lost time can be noticed later
   always_ff @(posedge clk_sys) begin
      if (!reset_n) begin
         osc_halt_flag_q <= 1'b1;
      end else if (stop_s2_q) begin
         osc_halt_flag_q <= 1'b1;
      end else if (osc_halt_clear) begin
         osc_halt_flag_q <= 1'b0;
      end
   end

   // Trim register; a write arms the adjustment, a halt clears it
   // Until the first write after reset or halt the adjustment stays
   // idle, even for a nonzero value
   always_ff @(posedge clk_sys) begin
      if (!reset_n) begin
         rate_trim_q <= btcc_pkg::TRIM_RESET;
         trim_active_q <= 1'b0;
      end else if (stop_s2_q) begin
         rate_trim_q <= btcc_pkg::TRIM_RESET;
         trim_active_q <= 1'b0;
      end else if (wr_trim) begin
         rate_trim_q <= reg_wdata & btcc_pkg::MASK_RATE_TRIM;
         trim_active_q <= 1'b1;
      end
   end

   // -------------------------------------------------------------------
   // Read back and tick output
   // -------------------------------------------------------------------
   // Address selects the field; unused bit positions come out as zero
   wire [7:0] rd_mux =
      (reg_addr == btcc_pkg::OFS_SECONDS) ? time_q.sec :
      (reg_addr == btcc_pkg::OFS_MINUTES) ? time_q.min :
      (reg_addr == btcc_pkg::OFS_HOURS) ? time_q.hour :
      (reg_addr == btcc_pkg::OFS_WEEKDAY) ? {5'h00, time_q.wday} :
      (reg_addr == btcc_pkg::OFS_DAY) ? time_q.day :
      (reg_addr == btcc_pkg::OFS_MONTH) ?
         {time_q.century, time_q.month[6:0]} :
      (reg_addr == btcc_pkg::OFS_YEAR) ? time_q.year :
      rate_trim_q;

   // Registered read data and second pulse
   // Read data follows the address one cycle later, every cycle
   always_ff @(posedge clk_sys) begin
      if (!reset_n) begin
         reg_rdata_q <= 8'h00;
         sec_tick_q <= 1'b0;
      end else begin
         reg_rdata_q <= rd_mux;
         sec_tick_q <= tick;
      end
   end

endmodule
`default_nettype wire

// ==== btcc_counters_checker.sv ====
/*
   Concurrent checks on the time and calendar counter block.
   Assumes it is bound to btcc_counters and sees only its ports.
*/
`timescale 1ns/1ps
`default_nettype none
module btcc_counters_checker (
   // Clock and reset
   input wire logic clk_sys,
   input wire logic reset_n,
   // Crystal side
   input wire logic xtal_clk,
   input wire logic osc_stop,
   // Register port
   input wire logic reg_wr_en,
   input wire logic [2:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic [7:0] reg_rdata_q,
   // Control and status
   input wire logic mode_24h,
   input wire logic osc_halt_clear,
   input wire logic osc_halt_flag_q,
   input wire logic sec_tick_q
);
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!reset_n);
   logic xtal_q;
   logic armed_q;
   logic [16:0] rise_q;
   wire logic sec_wr;
   wire logic [2:0] pa;
   assign sec_wr = reg_wr_en && reg_addr == btcc_pkg::OFS_SECONDS;
   // Crystal rises since the last tick or seconds write
   always_ff @(posedge clk_sys) begin
      xtal_q <= xtal_clk;
      armed_q <= reset_n && !osc_stop && (armed_q || sec_wr || sec_tick_q);
      if (!reset_n || sec_wr || sec_tick_q) begin
         rise_q <= 17'h00000;
      end else if (xtal_clk && !xtal_q) begin
         rise_q <= rise_q + 17'h00001;
      end
   end
   assign pa = reg_addr;
   property p_tick_len;
      sec_tick_q && armed_q |-> rise_q >= 17'd32643 && rise_q <= 17'd32893;
   endproperty
   a_tick_len: assert property (p_tick_len) else $error("second length");
   property p_sec_bcd;
      $past(pa) == btcc_pkg::OFS_SECONDS |->
         reg_rdata_q <= 8'h59 && reg_rdata_q[3:0] <= 4'h9;
   endproperty
   a_sec_bcd: assert property (p_sec_bcd) else $error("seconds range");
   property p_min_bcd;
      $past(pa) == btcc_pkg::OFS_MINUTES |->
         reg_rdata_q <= 8'h59 && reg_rdata_q[3:0] <= 4'h9;
   endproperty
   a_min_bcd: assert property (p_min_bcd) else $error("minutes range");
   property p_hour24;
      $past(mode_24h) && $past(pa) == btcc_pkg::OFS_HOURS |->
         reg_rdata_q <= 8'h23;
   endproperty
   a_hour24: assert property (p_hour24) else $error("hours range");
   property p_wday;
      $past(pa) == btcc_pkg::OFS_WEEKDAY |-> reg_rdata_q <= 8'h06;
   endproperty
   a_wday: assert property (p_wday) else $error("weekday range");
   property p_month;
      $past(reset_n) && $past(pa) == btcc_pkg::OFS_MONTH |->
         reg_rdata_q[6:5] == 2'h0 && reg_rdata_q[4:0] != 5'h00
         && reg_rdata_q[4:0] <= 5'h12;
   endproperty
   a_month: assert property (p_month) else $error("month range");
   property p_trim_wr;
      reg_wr_en && pa == btcc_pkg::OFS_RATE_TRIM && !osc_stop
         ##1 pa == btcc_pkg::OFS_RATE_TRIM && !osc_stop
         |=> reg_rdata_q == ($past(reg_wdata, 2) & 8'h7F);
   endproperty
   a_trim_wr: assert property (p_trim_wr) else $error("trim write");
   property p_halt_set;
      osc_stop [*4] |-> osc_halt_flag_q;
   endproperty
   a_halt_set: assert property (p_halt_set) else $error("halt flag");
   property p_halt_trim;
      osc_stop [*4] ##1 pa == btcc_pkg::OFS_RATE_TRIM |=> reg_rdata_q == 8'h00;
   endproperty
   a_halt_trim: assert property (p_halt_trim) else $error("trim kept");
   c_tick: cover property (sec_tick_q && armed_q);
   c_halt: cover property (osc_stop [*4]);
   c_secwr: cover property (sec_wr);
endmodule
bind btcc_counters btcc_counters_checker chk_u (.clk_sys(clk_sys),
   .reset_n(reset_n), .xtal_clk(xtal_clk), .osc_stop(osc_stop),
   .reg_wr_en(reg_wr_en), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
   .reg_rdata_q(reg_rdata_q), .mode_24h(mode_24h),
   .osc_halt_clear(osc_halt_clear), .osc_halt_flag_q(osc_halt_flag_q),
   .sec_tick_q(sec_tick_q));
`default_nettype wire

// ==== btcc_xtal_model.sv ====
/*
   Crystal oscillator model with a halt detector output.
   Assumes the bench raises halt_req to stop the crystal.
*/
`timescale 1ns/1ps
`default_nettype none
module btcc_xtal_model (
   // Control
   input wire logic halt_req,
   // Crystal side
   output logic xtal_clk,
   output logic osc_stop
);
   // 160 ns crystal, phase offset from the system clock, still when halted
   initial begin
      xtal_clk = 1'b0;
      #7;
      forever #80 xtal_clk = halt_req ? xtal_clk : ~xtal_clk;
   end
   assign osc_stop = halt_req;
endmodule
`default_nettype wire

// ==== btcc_counters_tb.sv ====
/*
   Self-checking bench for the time and calendar counters.
   Assumes the crystal model and the checker bound to the design.
*/
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, a) begin tests_run++; if ((a) !== (e)) begin \
   bad_count++; $display("ERROR %s exp %h got %h", n, e, a); end end
module btcc_counters_tb;
   logic clk_sys = 1'b0, reset_n = 1'b0, halt_req = 1'b0;
   logic reg_wr_en = 1'b0, mode_24h = 1'b1, osc_halt_clear = 1'b0;
   logic [2:0] reg_addr = 3'h0;
   logic [7:0] reg_wdata = 8'h00, rd_v, reg_rdata_q;
   logic xtal_clk, osc_stop, osc_halt_flag_q, sec_tick_q;
   int bad_count = 0, tests_run = 0;
   always #10 clk_sys = ~clk_sys;
   btcc_xtal_model xm_u (.halt_req(halt_req), .xtal_clk(xtal_clk),
      .osc_stop(osc_stop));
   btcc_counters dut_u (.clk_sys(clk_sys), .reset_n(reset_n),
      .xtal_clk(xtal_clk), .osc_stop(osc_stop), .reg_wr_en(reg_wr_en),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata_q(reg_rdata_q),
      .mode_24h(mode_24h), .osc_halt_clear(osc_halt_clear),
      .osc_halt_flag_q(osc_halt_flag_q), .sec_tick_q(sec_tick_q));
   // Verdict and end of run
   task give_verdict;
      $display("checks %0d errors %0d", tests_run, bad_count);
      if (bad_count == 0 && tests_run > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask
   // One register write, strobe for one cycle
   task wr(input logic [2:0] a, input logic [7:0] d);
      @(posedge clk_sys); #1;
      reg_wr_en = 1'b1; reg_addr = a; reg_wdata = d;
      @(posedge clk_sys); #1;
      reg_wr_en = 1'b0;
   endtask
   // Register read and compare
   task chk_rd(input logic [2:0] a, input logic [7:0] e);
      @(posedge clk_sys); #1;
      reg_addr = a;
      @(posedge clk_sys); #1;
      `CHK("register", e, reg_rdata_q)
   endtask
   // One-cycle clear pulse on the halt flag
   task clr_pulse;
      @(posedge clk_sys); #1;
      osc_halt_clear = 1'b1;
      @(posedge clk_sys); #1;
      osc_halt_clear = 1'b0;
      repeat (2) @(posedge clk_sys);
      #1;
   endtask
   // Values right after reset
   task t_reset;
      logic [7:0] ex [8];
      ex = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h01, 8'h01, 8'h00, 8'h00};
      `CHK("halt flag", 1'b1, osc_halt_flag_q)
      for (int i = 0; i < 8; i++) begin
         chk_rd(i[2:0], ex[i]);
      end
   endtask
   // Unused bits dropped on write
   task t_mask;
      wr(3'h0, 8'hD9);
      chk_rd(3'h0, 8'h59);
      wr(3'h7, 8'h7F);
      chk_rd(3'h7, 8'h7F);
      wr(3'h5, 8'hF2);
      chk_rd(3'h5, 8'h92);
   endtask
   // Crystal halt sets the flag and clears the trim
   task t_halt;
      wr(3'h7, 8'h05);
      @(posedge clk_sys); #1;
      halt_req = 1'b1;
      repeat (6) @(posedge clk_sys);
      chk_rd(3'h7, 8'h00);
      clr_pulse();
      `CHK("flag held", 1'b1, osc_halt_flag_q)
      halt_req = 1'b0;
      repeat (6) @(posedge clk_sys);
      clr_pulse();
      `CHK("flag clear", 1'b0, osc_halt_flag_q)
      // Stop the crystal again: the flag must set from clear
      halt_req = 1'b1;
      repeat (5) @(posedge clk_sys);
      #1;
      `CHK("flag set", 1'b1, osc_halt_flag_q)
      halt_req = 1'b0;
      repeat (4) @(posedge clk_sys);
      #1;
   endtask
   // Bounded wait for the next second pulse
   task wait_tick(output int n);
      n = 0;
      while (sec_tick_q !== 1'b1 && n < 300000) begin
         @(posedge clk_sys); #1;
         n++;
      end
      if (n == 300000) begin
         bad_count++;
         $display("ERROR wait for tick timed out");
         give_verdict();
      end
   endtask
   // Full rollover on one second, timed from the seconds write
   task t_roll;
      int n;
      logic [7:0] ex [7];
      ex = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h01, 8'h01, 8'h00};
      wr(3'h6, 8'h99);
      wr(3'h5, 8'h92);
      wr(3'h4, 8'h31);
      wr(3'h3, 8'h06);
      wr(3'h2, 8'h23);
      wr(3'h1, 8'h59);
      wr(3'h0, 8'h59);
      wait_tick(n);
      `CHK("second length", 1'b1, (n > 262100 && n < 262200))
      for (int i = 0; i < 7; i++) begin
         chk_rd(i[2:0], ex[i]);
      end
      // 12-hour mode: afternoon 11:59:59 rolls to midnight 12
      mode_24h = 1'b0;
      wr(3'h2, 8'h31);
      wr(3'h1, 8'h59);
      wr(3'h0, 8'h59);
      wait_tick(n);
      `CHK("second restart", 1'b1, (n > 262100 && n < 262200))
      chk_rd(3'h2, 8'h12);
      chk_rd(3'h4, 8'h02);
      chk_rd(3'h3, 8'h01);
      mode_24h = 1'b1;
   endtask
   // Main sequence
   initial begin
      repeat (4) @(posedge clk_sys);
      #1;
      reset_n = 1'b1;
      t_reset();
      t_mask();
      t_halt();
      t_roll();
      give_verdict();
   end
endmodule
`default_nettype wire
